// >>> bcca_map.svh
// Purpose: Offsets, flag positions, reset values and constants for the bcca datapath
// Assumes: Included by its bare name; definitions only
// Notes: Register offsets are byte addresses on the plain register port
`ifndef BCCA_MAP_SVH
`define BCCA_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BCCA_REG_ACC 4'h0
`define BCCA_REG_STAT 4'h4
`define BCCA_REG_WDT 4'h8

// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define BCCA_FLG_C 0
`define BCCA_FLG_AC 1
`define BCCA_FLG_Z 2
`define BCCA_FLG_TO 3
`define BCCA_FLG_PDF 4

// ----------------------------------------
// Reset values and byte constants
// ----------------------------------------
`define BCCA_ACC_RST 8'h00
`define BCCA_FLAG_RST 1'b0
`define BCCA_BYTE_ZERO 8'h00
`define BCCA_BYTE_ONES 8'hFF
`define BCCA_BIT_ONE 8'h01
`define BCCA_WORD_ZERO 32'h0000_0000
`define BCCA_WDT_LIMIT 65535

// ----------------------------------------
// Decimal adjust constants
// ----------------------------------------
`define BCCA_NIB_MAX 4'h9
`define BCCA_NIB_SIX 4'h6
`define BCCA_ADJ_00 8'h00
`define BCCA_ADJ_06 8'h06
`define BCCA_ADJ_60 8'h60
`define BCCA_ADJ_66 8'h66

`endif

// >>> bcca_pkg.sv
// Purpose: Types shared by the bcca datapath
// Assumes: Operation codes arrive on a 3-bit port
// Notes: Code 0 is an idle slot that does nothing
package bcca_pkg;

  typedef enum logic [2:0] {
    no_op                = 3'h0,
    clear_memory_bit_op  = 3'h1,
    watchdog_clear_op    = 3'h2,
    complement_in_place_op = 3'h3,
    complement_to_acc_op = 3'h4,
    decimal_adjust_op    = 3'h5
  } bcca_op_t;

endpackage

// >>> bcca_daa.sv
// Purpose: Decimal adjust of the accumulator after a BCD addition
// Assumes: Purely combinational; the caller registers the results
// Notes: Correction is one of four constants added to the whole byte
`timescale 1ns/1ns
`default_nettype none
`include "bcca_map.svh"
module bcca_daa
  import bcca_pkg::*;
(
  // Operand and incoming flags
  input wire logic [7:0] acc_i,
  input wire logic aux_carry_i,
  input wire logic carry_i,
  // Corrected byte and outgoing carry
  output logic [7:0] sum_o,
  output logic carry_o
);

  logic lo_fix;
  logic hi_fix;
  logic [7:0] adj;

  assign lo_fix = (acc_i[3:0] > `BCCA_NIB_MAX) || aux_carry_i;
  // A low nibble above 9 on a 9 high nibble carries it past 9 as well
  assign hi_fix = (acc_i[7:4] > `BCCA_NIB_MAX) || carry_i
                  || ((acc_i[7:4] == `BCCA_NIB_MAX) && (acc_i[3:0] > `BCCA_NIB_MAX));

  always_comb begin
    case ({hi_fix, lo_fix})
      2'b01: adj = `BCCA_ADJ_06;
      2'b10: adj = `BCCA_ADJ_60;
      2'b11: adj = `BCCA_ADJ_66;
      default: adj = `BCCA_ADJ_00;
    endcase
  end

  assign sum_o = acc_i + adj;
  // Carry is sticky through the adjust so multi-byte sums chain
  assign carry_o = carry_i || hi_fix;

endmodule
`default_nettype wire

// >>> bcca_alu.sv
// Purpose: Execution datapath for bit clear, watchdog clear, complement and decimal adjust
// Assumes: Memory byte for the operation is presented with the operation strobe
// Notes: Results, memory write and flags appear one cycle after the strobe
//
// How it works
// - Bit clear zeroes the chosen memory bit, keeps others, touches no flag.
// - Watchdog clear resets the watchdog counter and clears timeout and power-down flags, unless a time-out or power-down event sets one in the same cycle.
// - In-place complement inverts the memory byte, writes it back, updates zero flag.
// - Complement to accumulator loads inverted byte, memory untouched, zero flag updated.
// - Decimal adjust adds 6 to low nibble if above 9 or auxiliary carry.
// - Decimal adjust adds 6 to high nibble if above 9, if carry is set, or if it is 9 with low nibble above 9.
// - Decimal adjust adds 00H, 06H, 60H or 66H to the accumulator.
// - Decimal adjust changes only carry, set when the decimal sum overflows.
// - Decimal adjust result goes to the memory byte, not the accumulator.
`timescale 1ns/1ns
`default_nettype none
`include "bcca_map.svh"
module bcca_alu
  import bcca_pkg::*;
#(
  parameter int WDT_LIMIT = `BCCA_WDT_LIMIT,
  parameter int WDT_W = 16,
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Operation issue from the decoder
  input wire logic OP_VALID_I,
  input wire logic [2:0] OP_CODE_I,
  input wire logic [2:0] OP_BIT_I,
  input wire logic [ADDR_W-1:0] OP_ADDR_I,
  input wire logic [7:0] MEM_RDATA_I,
  input wire logic PWRDN_I,
  // Data memory write port
  output logic MEM_WE_O,
  output logic [ADDR_W-1:0] MEM_ADDR_O,
  output logic [7:0] MEM_WDATA_O,
  output logic DONE_O,
  // Accumulator and flags
  output logic [7:0] ACC_O,
  output logic CARRY_O,
  output logic AUX_CARRY_O,
  output logic ZERO_O,
  output logic TIMEOUT_O,
  output logic POWER_DOWN_O,
  // Register port
  input wire logic [3:0] BUS_ADDR_I,
  input wire logic [31:0] BUS_WDATA_I,
  input wire logic BUS_WR_I,
  input wire logic BUS_RD_I,
  output logic [31:0] BUS_RDATA_O
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] acc_q, acc_d;
  logic c_q, c_d;
  logic ac_q, ac_d;
  logic z_q, z_d;
  logic to_q, to_d;
  logic pdf_q, pdf_d;
  logic [WDT_W-1:0] wdt_q, wdt_d;
  logic mem_we_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic [7:0] mem_wdata_q, mem_wdata_d;
  logic done_q;
  logic [31:0] rdata_q, rdata_d;

  // ----------------------------------------
  // Operation decode
  // ----------------------------------------
  bcca_op_t op;
  wire do_clrbit;
  wire do_wdtc;
  wire do_cplm;
  wire do_cpla;
  wire do_daa;
  wire do_any;
  wire mem_we_d;

  assign op = bcca_op_t'(OP_CODE_I);
  assign do_clrbit = OP_VALID_I && (op == clear_memory_bit_op);
  assign do_wdtc = OP_VALID_I && (op == watchdog_clear_op);
  assign do_cplm = OP_VALID_I && (op == complement_in_place_op);
  assign do_cpla = OP_VALID_I && (op == complement_to_acc_op);
  assign do_daa = OP_VALID_I && (op == decimal_adjust_op);
  assign do_any = do_clrbit || do_wdtc || do_cplm || do_cpla || do_daa;

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  wire [7:0] bit_mask;
  wire [7:0] clr_val;
  wire [7:0] cpl_val;
  wire cpl_zero;
  wire [7:0] daa_sum;
  wire daa_carry;

  assign bit_mask = `BCCA_BIT_ONE << OP_BIT_I;
  assign clr_val = MEM_RDATA_I & ~bit_mask;
  assign cpl_val = ~MEM_RDATA_I;
  assign cpl_zero = (cpl_val == `BCCA_BYTE_ZERO);

  bcca_daa u_daa (
    .acc_i(acc_q),
    .aux_carry_i(ac_q),
    .carry_i(c_q),
    .sum_o(daa_sum),
    .carry_o(daa_carry)
  );

  // Complement to accumulator never writes memory
  assign mem_we_d = do_clrbit || do_cplm || do_daa;
  assign mem_wdata_d = do_clrbit ? clr_val :
                       do_cplm ? cpl_val :
                       do_daa ? daa_sum : `BCCA_BYTE_ZERO;

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  // Software writes are dropped in an operation cycle so the two never race
  wire wr_ok;
  wire wr_acc;
  wire wr_stat;
  wire hit_acc;
  wire hit_stat;
  wire hit_wdt;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;

  assign hit_acc = (BUS_ADDR_I == `BCCA_REG_ACC);
  assign hit_stat = (BUS_ADDR_I == `BCCA_REG_STAT);
  assign hit_wdt = (BUS_ADDR_I == `BCCA_REG_WDT);
  assign wr_ok = BUS_WR_I && !OP_VALID_I;
  assign wr_acc = wr_ok && hit_acc;
  assign wr_stat = wr_ok && hit_stat;

  always_comb begin
    stat_word = `BCCA_WORD_ZERO;
    stat_word[`BCCA_FLG_C] = c_q;
    stat_word[`BCCA_FLG_AC] = ac_q;
    stat_word[`BCCA_FLG_Z] = z_q;
    stat_word[`BCCA_FLG_TO] = to_q;
    stat_word[`BCCA_FLG_PDF] = pdf_q;
  end

  always_comb begin
    rd_mux = `BCCA_WORD_ZERO;
    if (hit_acc) begin
      rd_mux[7:0] = acc_q;
    end else if (hit_stat) begin
      rd_mux = stat_word;
    end else if (hit_wdt) begin
      rd_mux[WDT_W-1:0] = wdt_q;
    end
  end

  assign rdata_d = BUS_RD_I ? rd_mux : `BCCA_WORD_ZERO;

  // ----------------------------------------
  // Accumulator and flag next values
  // ----------------------------------------
  wire wdt_wrap;

  assign wdt_wrap = (wdt_q == WDT_W'(WDT_LIMIT));
  assign acc_d = do_cpla ? cpl_val : wr_acc ? BUS_WDATA_I[7:0] : acc_q;
  assign c_d = do_daa ? daa_carry : wr_stat ? BUS_WDATA_I[`BCCA_FLG_C] : c_q;
  assign ac_d = wr_stat ? BUS_WDATA_I[`BCCA_FLG_AC] : ac_q;
  assign z_d = (do_cplm || do_cpla) ? cpl_zero : wr_stat ? BUS_WDATA_I[`BCCA_FLG_Z] : z_q;
  // A time-out or power-down event in the clearing cycle is kept: set wins
  assign to_d = wdt_wrap ? 1'b1 : do_wdtc ? `BCCA_FLAG_RST : to_q;
  assign pdf_d = PWRDN_I ? 1'b1 : do_wdtc ? `BCCA_FLAG_RST : pdf_q;
  assign wdt_d = (do_wdtc || wdt_wrap) ? '0 : wdt_q + WDT_W'(1);

  // ----------------------------------------
  // Flip-flops
  // ----------------------------------------
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      acc_q <= `BCCA_ACC_RST;
      c_q <= `BCCA_FLAG_RST;
      ac_q <= `BCCA_FLAG_RST;
      z_q <= `BCCA_FLAG_RST;
      to_q <= `BCCA_FLAG_RST;
      pdf_q <= `BCCA_FLAG_RST;
      wdt_q <= '0;
    end else begin
      acc_q <= acc_d;
      c_q <= c_d;
      ac_q <= ac_d;
      z_q <= z_d;
      to_q <= to_d;
      pdf_q <= pdf_d;
      wdt_q <= wdt_d;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mem_we_q <= 1'b0;
      mem_addr_q <= '0;
      mem_wdata_q <= `BCCA_BYTE_ZERO;
      done_q <= 1'b0;
      rdata_q <= `BCCA_WORD_ZERO;
    end else begin
      mem_we_q <= mem_we_d;
      mem_addr_q <= OP_ADDR_I;
      mem_wdata_q <= mem_wdata_d;
      done_q <= do_any;
      rdata_q <= rdata_d;
    end
  end

  assign MEM_WE_O = mem_we_q;
  assign MEM_ADDR_O = mem_addr_q;
  assign MEM_WDATA_O = mem_wdata_q;
  assign DONE_O = done_q;
  assign ACC_O = acc_q;
  assign CARRY_O = c_q;
  assign AUX_CARRY_O = ac_q;
  assign ZERO_O = z_q;
  assign TIMEOUT_O = to_q;
  assign POWER_DOWN_O = pdf_q;
  assign BUS_RDATA_O = rdata_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  wire [3:0] lo_exp;
  wire [7:0] adj_seen;
  logic [7:0] acc_prev_q;

  // Issue-time accumulator kept in a flop, so the constant check needs no sampled-value call
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      acc_prev_q <= `BCCA_ACC_RST;
    end else begin
      acc_prev_q <= acc_q;
    end
  end

  assign lo_exp = ((acc_q[3:0] > `BCCA_NIB_MAX) || ac_q) ? acc_q[3:0] + `BCCA_NIB_SIX : acc_q[3:0];
  assign adj_seen = MEM_WDATA_O - acc_prev_q;

  bit_clear_a: assert property (
    do_clrbit |=> MEM_WE_O && (MEM_WDATA_O == $past(clr_val)) && !MEM_WDATA_O[$past(OP_BIT_I)]
      && $stable(CARRY_O) && $stable(ZERO_O) && $stable(ACC_O))
    else $error("bit clear result or flags wrong");

  wdt_clear_a: assert property (
    (do_wdtc && !wdt_wrap && !PWRDN_I) |=> !TIMEOUT_O && !POWER_DOWN_O && (wdt_q == '0)
      && !MEM_WE_O && $stable(CARRY_O))
    else $error("watchdog clear left a flag or the counter set");

  cpl_mem_a: assert property (
    do_cplm |=> MEM_WE_O && (MEM_WDATA_O == ~$past(MEM_RDATA_I)) && (MEM_ADDR_O == $past(OP_ADDR_I)))
    else $error("in-place complement wrong");

  cpl_acc_a: assert property (
    do_cpla |=> !MEM_WE_O && (ACC_O == ~$past(MEM_RDATA_I)))
    else $error("complement to accumulator wrong");

  daa_low_a: assert property (
    do_daa |=> MEM_WDATA_O[3:0] == $past(lo_exp))
    else $error("decimal adjust low nibble wrong");

  daa_high_a: assert property (
    (do_daa && (acc_q[7:4] > `BCCA_NIB_MAX)) |=> CARRY_O && (MEM_WDATA_O[7:4] < 4'h7))
    else $error("decimal adjust high nibble not corrected");

  daa_const_a: assert property (
    do_daa |=> (adj_seen == `BCCA_ADJ_00) || (adj_seen == `BCCA_ADJ_06)
      || (adj_seen == `BCCA_ADJ_60) || (adj_seen == `BCCA_ADJ_66))
    else $error("decimal adjust added an illegal constant");

  daa_flags_a: assert property (
    (do_daa && c_q) |=> CARRY_O ##0 $stable(ZERO_O) ##0 $stable(AUX_CARRY_O))
    else $error("decimal adjust touched a flag other than carry");

  daa_dest_a: assert property (
    do_daa |=> MEM_WE_O && (MEM_ADDR_O == $past(OP_ADDR_I)) && $stable(ACC_O) ##1 !MEM_WE_O || $past(do_any))
    else $error("decimal adjust result not sent to memory");

  zero_flag_a: assert property (
    (do_cplm || do_cpla) |=> ZERO_O == ($past(MEM_RDATA_I) == `BCCA_BYTE_ONES))
    else $error("zero flag after complement wrong");

  bus_read_a: assert property (
    (BUS_RD_I && hit_acc) |=> BUS_RDATA_O[7:0] == $past(acc_q) ##1 (BUS_RDATA_O == '0) || $past(BUS_RD_I))
    else $error("register read data wrong or held");

  cov_clrbit_c: cover property (do_clrbit ##1 MEM_WE_O);
  cov_daa_fix_c: cover property (do_daa && (acc_q[3:0] > `BCCA_NIB_MAX) && (acc_q[7:4] > `BCCA_NIB_MAX));
  cov_cpl_zero_c: cover property (do_cpla && (MEM_RDATA_I == `BCCA_BYTE_ONES));
  cov_wdt_c: cover property (TIMEOUT_O ##1 do_wdtc ##1 !TIMEOUT_O);

endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the bcca datapath against a bench model
// Assumes: Watchdog limit shortened to 15 so time-outs come quickly
// Notes: Time-out flag is only compared in the watchdog test, where its timing is known
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import bcca_pkg::*;
;
  // ----------------------------------------
  // Clock, reset and design ports
  // ----------------------------------------
  logic CLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  logic OP_VALID_I = 1'b0, PWRDN_I = 1'b0, BUS_WR_I = 1'b0, BUS_RD_I = 1'b0;
  logic [2:0] OP_CODE_I = 3'h0, OP_BIT_I = 3'h0;
  logic [7:0] OP_ADDR_I = 8'h00, MEM_RDATA_I = 8'h00, ACC_O, MEM_ADDR_O, MEM_WDATA_O;
  logic [3:0] BUS_ADDR_I = 4'h0;
  logic [31:0] BUS_WDATA_I = 32'h0000_0000, BUS_RDATA_O, rd;
  logic MEM_WE_O, DONE_O, CARRY_O, AUX_CARRY_O, ZERO_O, TIMEOUT_O, POWER_DOWN_O;
  int err_total = 0, compares = 0;
  logic [7:0] m_acc;
  logic m_c, m_ac, m_z;
  always #4 CLK_I = ~CLK_I;

  bcca_alu #(.WDT_LIMIT(15), .WDT_W(16), .ADDR_W(8)) DUT (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
    .OP_VALID_I(OP_VALID_I), .OP_CODE_I(OP_CODE_I), .OP_BIT_I(OP_BIT_I), .OP_ADDR_I(OP_ADDR_I),
    .MEM_RDATA_I(MEM_RDATA_I), .PWRDN_I(PWRDN_I), .MEM_WE_O(MEM_WE_O), .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_WDATA_O(MEM_WDATA_O), .DONE_O(DONE_O), .ACC_O(ACC_O), .CARRY_O(CARRY_O),
    .AUX_CARRY_O(AUX_CARRY_O), .ZERO_O(ZERO_O), .TIMEOUT_O(TIMEOUT_O), .POWER_DOWN_O(POWER_DOWN_O),
    .BUS_ADDR_I(BUS_ADDR_I), .BUS_WDATA_I(BUS_WDATA_I), .BUS_WR_I(BUS_WR_I), .BUS_RD_I(BUS_RD_I),
    .BUS_RDATA_O(BUS_RDATA_O));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    BUS_WR_I <= 1'b1;
    BUS_ADDR_I <= a;
    BUS_WDATA_I <= d;
    @(posedge CLK_I);
    BUS_WR_I <= 1'b0;
    BUS_WDATA_I <= ~d;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge CLK_I);
    BUS_RD_I <= 1'b1;
    BUS_ADDR_I <= a;
    @(posedge CLK_I);
    BUS_RD_I <= 1'b0;
    #1;
    d = BUS_RDATA_O;
  endtask

  task automatic set_state(input logic [7:0] a, input logic c, input logic ac, input logic z);
    bus_wr(4'h0, {24'h0000_00, a});
    bus_wr(4'h4, {29'h000_0000, z, ac, c});
    m_acc = a;
    m_c = c;
    m_ac = ac;
    m_z = z;
  endtask

  // ----------------------------------------
  // One operation against the model
  // ----------------------------------------
  task automatic do_op(input logic [2:0] code, input logic [2:0] bi, input logic [7:0] m);
    logic [7:0] ew, adj, ad;
    logic ewe, ed, hf;
    ew = 8'h00;
    ewe = 1'b0;
    ed = (code >= 3'h1 && code <= 3'h5);
    ad = 8'($urandom);
    adj = 8'h00;
    hf = 1'b0;
    case (code)
      3'h1: begin ewe = 1'b1; ew = m & ~(8'h01 << bi); end
      3'h3: begin ewe = 1'b1; ew = ~m; m_z = (ew == 8'h00); end
      3'h4: begin m_acc = ~m; m_z = (m_acc == 8'h00); end
      3'h5: begin
        if (m_acc[3:0] > 4'h9 || m_ac) adj = adj + 8'h06;
        hf = m_acc[7:4] > 4'h9 || m_c || (m_acc[7:4] == 4'h9 && m_acc[3:0] > 4'h9);
        if (hf) adj = adj + 8'h60;
        ewe = 1'b1;
        ew = m_acc + adj;
        m_c = m_c | hf;
      end
      default: ;
    endcase
    @(posedge CLK_I);
    OP_VALID_I <= 1'b1;
    OP_CODE_I <= code;
    OP_BIT_I <= bi;
    OP_ADDR_I <= ad;
    MEM_RDATA_I <= m;
    @(posedge CLK_I);
    OP_VALID_I <= 1'b0;
    MEM_RDATA_I <= ~m;
    #1;
    chk("done", {31'h0, ed}, {31'h0, DONE_O});
    chk("mem_we", {31'h0, ewe}, {31'h0, MEM_WE_O});
    chk("mem_wdata", {24'h0, ew}, {24'h0, MEM_WDATA_O});
    if (ewe) chk("mem_addr", {24'h0, ad}, {24'h0, MEM_ADDR_O});
    chk("acc", {24'h0, m_acc}, {24'h0, ACC_O});
    chk("flags", {29'h0, m_z, m_ac, m_c}, {29'h0, ZERO_O, AUX_CARRY_O, CARRY_O});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  logic [7:0] daa_tab [8] = '{8'h9B, 8'h99, 8'h0A, 8'h3F, 8'hA0, 8'h93, 8'h00, 8'h9A};
  initial begin
    void'($urandom(32'he15d));
    repeat (10) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    @(posedge CLK_I);
    // Bit clear on every bit, flags preset so any disturbance shows
    set_state(8'h5A, 1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) do_op(3'h1, 3'(i), 8'($urandom) | 8'h01 << i);
    // Complements, including all-ones and all-zeros bytes for the zero flag
    do_op(3'h3, 3'h0, 8'hFF);
    do_op(3'h3, 3'h0, 8'h00);
    do_op(3'h4, 3'h0, 8'hFF);
    do_op(3'h4, 3'h0, 8'h00);
    // Decimal adjust: table corners, then random accumulator and flags
    for (int i = 0; i < 32; i++) begin
      set_state(i < 8 ? daa_tab[i] : 8'($urandom), (i == 5) | (i > 7 && $urandom % 2 == 1),
                (i == 3) | (i > 7 && $urandom % 2 == 1), 1'b1);
      do_op(3'h5, 3'h0, 8'($urandom));
    end
    // Idle codes must do nothing
    foreach (daa_tab[i]) if (i < 3) do_op(i == 0 ? 3'h0 : 3'(5 + i), 3'h0, 8'h3C);
    // Random mix of the byte operations and watchdog clear
    for (int i = 0; i < 40; i++) do_op(3'($urandom % 5) + 3'h1, 3'($urandom), 8'($urandom));
    // Watchdog clear after a power-down event and a time-out
    // A first clear fixes the counter phase so the checked clear never meets a wrap
    do_op(3'h2, 3'h0, 8'h00);
    @(posedge CLK_I);
    PWRDN_I <= 1'b1;
    @(posedge CLK_I);
    PWRDN_I <= 1'b0;
    repeat (20) @(posedge CLK_I);
    #1;
    chk("to_pdf_set", 32'h3, {30'h0, TIMEOUT_O, POWER_DOWN_O});
    do_op(3'h2, 3'h0, 8'h00);
    chk("to_pdf_clr", 32'h0, {30'h0, TIMEOUT_O, POWER_DOWN_O});
    bus_rd(4'h4, rd);
    chk("status", {27'h0, 2'b00, m_z, m_ac, m_c}, rd);
    bus_rd(4'h8, rd);
    chk("wdt_count", 32'h0000_0003, rd);
    // Register port: accumulator readback and an unmapped place
    bus_wr(4'h0, 32'hFFFF_FFA5);
    bus_rd(4'h0, rd);
    chk("acc_reg", 32'h0000_00A5, rd);
    bus_wr(4'hC, 32'h1234_5678);
    bus_rd(4'hC, rd);
    chk("unmapped", 32'h0000_0000, rd);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge CLK_I);
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
